/* File: src/aed_check.sv */
/*
  Combinational classifier of one bus access: raises err_out when the access is illegal.
  Assumes the caller qualifies the result with the access valid bit.
*/
`timescale 1ns/1ns
module aed_check (
  // Access under test
  input wire aed_pkg::aed_access_t acc_in,
  // Verdict
  output logic err_out
);
  import aed_pkg::*;

  logic peri;
  logic is_long;
  logic special;

  always_comb begin
    peri = acc_in.addr >= AED_PERI_LO;
    // Block transfers go out as longwords
    is_long = (acc_in.size == AED_SZ_LONG) || (acc_in.size == AED_SZ_BLK16);
    special = aed_space(acc_in.addr, AED_SPC_PURGE) || aed_space(acc_in.addr, AED_SPC_ADDR_ARR) ||
              aed_space(acc_in.addr, AED_SPC_SDRAM_MODE) || peri;
    err_out = 1'b0;
    if (acc_in.sdram_mrw) begin
      err_out = 1'b0;
    end else if (acc_in.fetch) begin
      err_out = acc_in.addr[0] || peri;
    end else begin
      if (acc_in.size == AED_SZ_WORD && acc_in.addr[0]) begin
        err_out = 1'b1;
      end
      if (is_long && acc_in.addr[1:0] != 2'h0) begin
        err_out = 1'b1;
      end
      if (acc_in.pc_rel && special) begin
        err_out = 1'b1;
      end
      if (acc_in.tas && (special || aed_space(acc_in.addr, AED_SPC_DATA_ARR))) begin
        err_out = 1'b1;
      end
      // Region A takes every size; B rejects longwords; C rejects bytes
      if (aed_in_range(acc_in.addr, AED_PERI_B_LO, AED_PERI_B_HI) && is_long) begin
        err_out = 1'b1;
      end
      if (aed_in_range(acc_in.addr, AED_PERI_LO, AED_PERI_C_HI) && acc_in.size == AED_SZ_BYTE) begin
        err_out = 1'b1;
      end
    end
  end

endmodule : aed_check

/* File: src/aed_pkg.sv */
/*
  Shared types and constants for the address error detector.
  Assumes one bus access is presented per cycle by whichever master owns the bus.
*/
package aed_pkg;

  typedef enum logic [1:0] {AED_SZ_BYTE, AED_SZ_WORD, AED_SZ_LONG, AED_SZ_BLK16} aed_size_t;
  typedef enum logic [1:0] {AED_M_CPU, AED_M_DMA, AED_M_EDMA} aed_master_t;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_PUSH_STAT, ST_PUSH_PC, ST_FETCH} aed_state_t;

  typedef struct packed {
    logic valid;
    aed_master_t master;
    aed_size_t size;
    logic fetch;
    logic pc_rel;
    logic tas;
    logic sdram_mrw;
    logic [31:0] addr;
  } aed_access_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } aed_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] target;
    logic [31:0] sp;
  } aed_jump_t;

  typedef struct packed {
    logic cpu;
    logic dma;
    logic edma;
  } aed_err_src_t;

  // Peripheral module space and its sub-regions
  localparam logic [31:0] AED_PERI_LO = 32'hFFFF0000;
  localparam logic [31:0] AED_PERI_C_HI = 32'hFFFFFBFF;
  localparam logic [31:0] AED_PERI_A_LO = 32'hFFFFFC00;
  localparam logic [31:0] AED_PERI_A_HI = 32'hFFFFFCFF;
  localparam logic [31:0] AED_PERI_B_LO = 32'hFFFFFE00;
  localparam logic [31:0] AED_PERI_B_HI = 32'hFFFFFEFF;
  localparam logic [31:0] AED_PERI_TOP = 32'hFFFFFFFF;

  // Special spaces, selected by the top address nibble
  localparam logic [3:0] AED_SPC_PURGE = 4'h4;
  localparam logic [3:0] AED_SPC_ADDR_ARR = 4'h6;
  localparam logic [3:0] AED_SPC_DATA_ARR = 4'hC;
  localparam logic [3:0] AED_SPC_SDRAM_MODE = 4'hE;

  localparam logic [7:0] AED_VEC_DMA_ERR = 8'h0A;
  // Processor vector value is arbitrary, kept apart from the shared DMA one
  localparam logic [7:0] AED_VEC_CPU_ERR = 8'h09;
  localparam logic [31:0] AED_STACK_STEP = 32'h00000004;

  function automatic logic aed_in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : aed_in_range

  function automatic logic aed_space(input logic [31:0] a, input logic [3:0] tag);
    return a[31:28] == tag;
  endfunction : aed_space

  function automatic logic [31:0] aed_vec_addr(input logic [31:0] base, input logic [7:0] vec);
    return base + {22'h000000, vec, 2'h0};
  endfunction : aed_vec_addr

endpackage : aed_pkg

/* File: src/aed_unit.sv */
/*
  Address error detector and exception entry sequencer.
  Assumes a core that reports bus cycle end and instruction completion, and a memory
  port that answers each request with a one-cycle ack (read data valid with it).
*/
`timescale 1ns/1ns
module aed_unit (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Observed bus access
  input wire aed_pkg::aed_access_t acc_in,
  // Core progress and context
  input wire logic bus_end_in,
  input wire logic insn_done_in,
  input wire logic [31:0] next_pc_in,
  input wire logic [31:0] status_in,
  input wire logic [31:0] sp_in,
  input wire logic [31:0] vector_base_in,
  // Memory port answers
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  // Error reports
  output aed_pkg::aed_err_src_t err_src_out,
  output logic addr_err_out,
  output logic busy_out,
  // Exception entry traffic
  output aed_pkg::aed_mem_req_t mem_out,
  output aed_pkg::aed_jump_t jump_out
);
  import aed_pkg::*;

  typedef struct packed {
    aed_state_t state;
    logic err;
    aed_err_src_t src;
    logic seen_end;
    logic seen_done;
    logic [7:0] vec;
    logic [31:0] stat;
    logic [31:0] pc;
    logic [31:0] sp;
    aed_mem_req_t mem;
    aed_jump_t jump;
    logic busy;
  } aed_regs_t;

  aed_regs_t r;
  aed_regs_t n;
  logic chk_err;
  logic hit;

  aed_check u_check (
    .acc_in(acc_in),
    .err_out(chk_err)
  );

  assign hit = acc_in.valid && chk_err;

  always_comb begin
    n = r;
    n.err = 1'b0;
    n.src = '0;
    n.jump.valid = 1'b0;
    case (r.state)
      ST_IDLE: begin
        // Later errors during entry are dropped; the first one owns the vector
        if (hit) begin
          n.err = 1'b1;
          n.src.cpu = acc_in.master == AED_M_CPU;
          n.src.dma = acc_in.master == AED_M_DMA;
          n.src.edma = acc_in.master == AED_M_EDMA;
          n.vec = (acc_in.master == AED_M_CPU) ? AED_VEC_CPU_ERR : AED_VEC_DMA_ERR;
          n.seen_end = bus_end_in;
          n.seen_done = insn_done_in;
          if (insn_done_in) begin
            n.pc = next_pc_in;
            n.stat = status_in;
          end
          n.busy = 1'b1;
          n.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (bus_end_in) begin
          n.seen_end = 1'b1;
        end
        if (insn_done_in && !r.seen_done) begin
          n.seen_done = 1'b1;
          n.pc = next_pc_in;
          n.stat = status_in;
        end
        if (n.seen_end && n.seen_done) begin
          n.sp = sp_in - AED_STACK_STEP;
          n.mem.req = 1'b1;
          n.mem.write = 1'b1;
          n.mem.addr = sp_in - AED_STACK_STEP;
          n.mem.wdata = n.stat;
          n.state = ST_PUSH_STAT;
        end
      end
      ST_PUSH_STAT: begin
        if (mem_ack_in) begin
          n.sp = r.sp - AED_STACK_STEP;
          n.mem.addr = r.sp - AED_STACK_STEP;
          n.mem.wdata = r.pc;
          n.state = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (mem_ack_in) begin
          n.mem.write = 1'b0;
          n.mem.wdata = '0;
          n.mem.addr = aed_vec_addr(vector_base_in, r.vec);
          n.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // Straight jump: no slot instruction runs before the handler
        if (mem_ack_in) begin
          n.mem = '0;
          n.jump.valid = 1'b1;
          n.jump.target = mem_rdata_in;
          n.jump.sp = r.sp;
          n.seen_end = 1'b0;
          n.seen_done = 1'b0;
          n.busy = 1'b0;
          n.state = ST_IDLE;
        end
      end
      default: begin
        n = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign addr_err_out = r.err;
  assign err_src_out = r.src;
  assign busy_out = r.busy;
  assign mem_out = r.mem;
  assign jump_out = r.jump;

  // Checks; "idle" means a new error would be taken
  logic idle;
  logic data_ok;
  assign idle = r.state == ST_IDLE;
  assign data_ok = acc_in.valid && idle && !acc_in.fetch && !acc_in.pc_rel && !acc_in.tas;

  a_fetch_odd: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && idle && acc_in.fetch && acc_in.addr[0] && !acc_in.sdram_mrw |=> addr_err_out)
    else $error("odd fetch not flagged");

  a_fetch_peri: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && idle && acc_in.fetch && !acc_in.sdram_mrw && acc_in.addr >= AED_PERI_LO
    |=> addr_err_out ##1 busy_out)
    else $error("peripheral fetch not flagged");

  a_word_odd: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && !acc_in.sdram_mrw && acc_in.size == AED_SZ_WORD && acc_in.addr[0]
    |=> addr_err_out && (err_src_out != '0))
    else $error("odd word access not flagged");

  a_long_align: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && !acc_in.sdram_mrw && acc_in.size inside {AED_SZ_LONG, AED_SZ_BLK16}
    && acc_in.addr[1:0] != 2'h0 |=> addr_err_out)
    else $error("misaligned longword not flagged");

  a_pcrel_space: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && idle && !acc_in.fetch && acc_in.pc_rel && !acc_in.sdram_mrw
    && aed_space(acc_in.addr, AED_SPC_PURGE) |=> addr_err_out)
    else $error("pc-relative purge access not flagged");

  a_tas_space: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && idle && !acc_in.fetch && acc_in.tas && !acc_in.sdram_mrw
    && aed_space(acc_in.addr, AED_SPC_DATA_ARR) |=> addr_err_out)
    else $error("test-and-set array access not flagged");

  a_peri_a_ok: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && acc_in.size == AED_SZ_BYTE && aed_in_range(acc_in.addr, AED_PERI_A_LO, AED_PERI_A_HI)
    |=> !addr_err_out)
    else $error("region A byte access flagged");

  a_peri_b_long: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && !acc_in.sdram_mrw && acc_in.size == AED_SZ_LONG
    && aed_in_range(acc_in.addr, AED_PERI_B_LO, AED_PERI_B_HI) |=> addr_err_out)
    else $error("region B longword not flagged");

  a_peri_b_short: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && acc_in.size == AED_SZ_BYTE && acc_in.addr >= AED_PERI_B_LO |=> !addr_err_out)
    else $error("upper region byte access flagged");

  a_peri_c_byte: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && !acc_in.sdram_mrw && acc_in.size == AED_SZ_BYTE
    && aed_in_range(acc_in.addr, AED_PERI_LO, AED_PERI_C_HI) |=> addr_err_out)
    else $error("region C byte access not flagged");

  a_peri_c_word: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && acc_in.size == AED_SZ_WORD && !acc_in.addr[0]
    && aed_in_range(acc_in.addr, AED_PERI_LO, AED_PERI_C_HI) |=> !addr_err_out)
    else $error("region C word access flagged");

  a_mrw_quiet: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && acc_in.sdram_mrw |=> !addr_err_out)
    else $error("error during mode register write");

  a_entry_wait: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $rose(mem_out.req) |-> r.seen_end && r.seen_done && $past(r.state) == ST_WAIT)
    else $error("entry started before cycle end and instruction done");

  a_push_order: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    r.state == ST_PUSH_STAT && mem_ack_in |=> mem_out.write && mem_out.wdata == r.pc
    && mem_out.addr == $past(mem_out.addr) - AED_STACK_STEP)
    else $error("program counter push out of order");

  a_vec_addr: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    r.state == ST_FETCH |-> !mem_out.write && mem_out.addr == vector_base_in + {22'h000000, r.vec, 2'h0})
    else $error("wrong vector entry address");

  a_jump_now: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    r.state == ST_FETCH && mem_ack_in |=> jump_out.valid && jump_out.target == $past(mem_rdata_in)
    && idle)
    else $error("handler jump missing or late");

  a_dma_vec: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    addr_err_out && (err_src_out.dma || err_src_out.edma) |-> r.vec == AED_VEC_DMA_ERR)
    else $error("DMA error with wrong vector");

  a_cpu_vec: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    addr_err_out && err_src_out.cpu |-> r.vec == AED_VEC_CPU_ERR)
    else $error("processor error with wrong vector");

  a_fetch_even: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && idle && acc_in.fetch && !acc_in.addr[0] && acc_in.addr < AED_PERI_LO |=> !addr_err_out)
    else $error("legal fetch flagged");

  a_pcrel_peri: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && idle && !acc_in.fetch && acc_in.pc_rel && !acc_in.sdram_mrw
    && (acc_in.addr >= AED_PERI_LO || aed_space(acc_in.addr, AED_SPC_ADDR_ARR)
    || aed_space(acc_in.addr, AED_SPC_SDRAM_MODE)) |=> addr_err_out)
    else $error("pc-relative special access not flagged");

  a_tas_special: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    acc_in.valid && idle && !acc_in.fetch && acc_in.tas && !acc_in.sdram_mrw
    && (acc_in.addr >= AED_PERI_LO || aed_space(acc_in.addr, AED_SPC_PURGE)
    || aed_space(acc_in.addr, AED_SPC_ADDR_ARR) || aed_space(acc_in.addr, AED_SPC_SDRAM_MODE)) |=> addr_err_out)
    else $error("test-and-set special access not flagged");

  a_busy_quiet: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !idle && hit |=> !addr_err_out && $stable(r.vec))
    else $error("error taken while entry in progress");

  a_wait_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    r.state == ST_WAIT |-> !mem_out.req && busy_out)
    else $error("request raised while waiting");

  a_stat_push: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $rose(mem_out.req) |-> mem_out.write && mem_out.wdata == r.stat && mem_out.addr == r.sp)
    else $error("status word not pushed first");

  a_err_busy: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    addr_err_out |-> busy_out && r.state == ST_WAIT && $onehot(err_src_out))
    else $error("error pulse without entry");

  a_jump_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    jump_out.valid |-> !busy_out && !mem_out.req && r.state == ST_IDLE)
    else $error("jump while entry still running");

  c_cpu_entry: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    addr_err_out && err_src_out.cpu ##[1:40] jump_out.valid);
  c_dma_entry: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    addr_err_out && err_src_out.dma ##[1:40] jump_out.valid);
  c_edma_err: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    addr_err_out && err_src_out.edma);
  c_blk_err: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    data_ok && acc_in.size == AED_SZ_BLK16 && chk_err);
  c_slow_push: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    r.state == ST_PUSH_STAT ##1 r.state == ST_PUSH_STAT);

endmodule : aed_unit

/* File: testbench/address_error_detect_test.sv */
/*
  Self-checking bench for the address error unit: corner and random accesses, full entry sequence.
  Assumes aed_unit and the memory model above; one clock, synchronous reset.
*/
`timescale 1ns/1ns
module address_error_detect_test;
  import aed_pkg::*;
  localparam logic [31:0] HXOR = 32'hA5A50000;
  localparam logic [3:0] TOPS [6] = '{4'h0, 4'h4, 4'h6, 4'hC, 4'hE, 4'hF};
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  aed_access_t acc_r = '0;
  logic bus_end_r = 1'b0;
  logic done_r = 1'b0;
  logic slow_r = 1'b0;
  logic [31:0] pc_r = 32'h0, stat_r = 32'h0, sp_r = 32'h0, vbase_r = 32'h0;
  logic ack, addr_err, busy;
  logic [31:0] rdata;
  aed_err_src_t src;
  aed_mem_req_t mem;
  aed_jump_t jmp;
  aed_mem_req_t log_q[$];
  time ack_t;
  int errors = 0;
  int samples_checked = 0;

  always #20 sys_clk_in = ~sys_clk_in;

  aed_unit dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .acc_in(acc_r), .bus_end_in(bus_end_r),
    .insn_done_in(done_r), .next_pc_in(pc_r), .status_in(stat_r), .sp_in(sp_r), .vector_base_in(vbase_r),
    .mem_ack_in(ack), .mem_rdata_in(rdata), .err_src_out(src), .addr_err_out(addr_err),
    .busy_out(busy), .mem_out(mem), .jump_out(jmp));

  aed_mem_model #(.HANDLER_XOR(HXOR)) mem_model (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .mem_in(mem), .slow_in(slow_r), .ack_out(ack), .rdata_out(rdata));

  always @(posedge sys_clk_in) begin
    if (mem.req && ack) begin
      log_q.push_back(mem);
      ack_t = $time;
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  function automatic aed_access_t mk(input aed_master_t m, input aed_size_t s, input logic [3:0] f,
    input logic [31:0] ad);
    return '{1'b1, m, s, f[3], f[2], f[1], f[0], ad};
  endfunction : mk

  function automatic logic exp_err(input aed_access_t a);
    logic peri, bad;
    peri = a.addr >= 32'hFFFF0000;
    if (a.sdram_mrw) return 1'b0;
    if (a.fetch) return a.addr[0] || peri;
    bad = (a.size == AED_SZ_WORD) && a.addr[0];
    if (a.size inside {AED_SZ_LONG, AED_SZ_BLK16} && a.addr[1:0] != 2'h0) bad = 1'b1;
    if (a.pc_rel && (a.addr[31:28] inside {4'h4, 4'h6, 4'hE} || peri)) bad = 1'b1;
    if (a.tas && (a.addr[31:28] inside {4'h4, 4'h6, 4'hC, 4'hE} || peri)) bad = 1'b1;
    if (a.size == AED_SZ_BYTE && peri && a.addr <= 32'hFFFFFBFF) bad = 1'b1;
    if (a.size inside {AED_SZ_LONG, AED_SZ_BLK16} && a.addr[31:8] == 24'hFFFFFE) bad = 1'b1;
    return bad;
  endfunction : exp_err

  function automatic aed_access_t rand_acc();
    aed_access_t a;
    int k;
    a = '0;
    a.valid = 1'b1;
    k = $urandom_range(0, 5);
    a.addr = $urandom;
    a.addr[31:28] = TOPS[k];
    if (k == 5) a.addr[27:16] = 12'hFFF;
    if (k == 5 && $urandom_range(0, 1)) a.addr[15:8] = $urandom_range(0, 1) ? 8'hFE : 8'hFC;
    if ($urandom_range(0, 1)) a.addr[1:0] = 2'h0;
    a.master = aed_master_t'($urandom_range(0, 2));
    a.size = aed_size_t'($urandom_range(0, 3));
    a.sdram_mrw = ($urandom_range(0, 7) == 0);
    if (a.master == AED_M_CPU) begin
      k = $urandom_range(0, 3);
      a.fetch = (k == 1);
      a.pc_rel = (k == 2);
      a.tas = (k == 3);
      if (a.size == AED_SZ_BLK16 || a.fetch) a.size = AED_SZ_WORD;
      if (a.tas) a.size = AED_SZ_BYTE;
    end
    return a;
  endfunction : rand_acc

  task automatic run_entry(input logic [7:0] vec);
    int d1, d2, n;
    logic [31:0] va;
    va = vbase_r + {22'h0, vec, 2'h0};
    d1 = $urandom_range(0, 3);
    d2 = $urandom_range(0, 3);
    log_q.delete();
    chk_bit(busy, 1'b1, "busy after error");
    for (n = 0; n <= (d1 > d2 ? d1 : d2); n++) begin
      @(posedge sys_clk_in);
      bus_end_r <= (n == d1);
      done_r <= (n == d2);
      // Same bad access again while busy: must be ignored
      acc_r.valid <= (n == 0);
      #1;
      chk_bit(mem.req, 1'b0, "request before completion");
      chk_bit(addr_err, 1'b0, "error while busy");
    end
    @(posedge sys_clk_in);
    bus_end_r <= 1'b0;
    done_r <= 1'b0;
    acc_r.valid <= 1'b0;
    #1;
    chk_bit(mem.req, 1'b1, "request after completion");
    chk_bit(addr_err, 1'b0, "error while busy");
    for (n = 0; n < 40 && jmp.valid !== 1'b1; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk_bit(jmp.valid, 1'b1, "jump pulse");
    chk_word(32'($time - ack_t), 32'h1, "jump right after vector read");
    chk_word(jmp.target, va ^ HXOR, "handler address");
    chk_word(jmp.sp, sp_r - 32'h8, "stack after pushes");
    chk_bit(busy, 1'b0, "busy at jump");
    chk_word(32'(log_q.size()), 32'h3, "request count");
    for (n = 0; n < 3 && n < log_q.size(); n++) begin
      chk_word(log_q[n].addr, n == 0 ? sp_r - 32'h4 : (n == 1 ? sp_r - 32'h8 : va), "address");
      chk_bit(log_q[n].write, n < 2, "direction");
      if (n < 2) chk_word(log_q[n].wdata, n == 0 ? stat_r : pc_r, "pushed word");
    end
  endtask : run_entry

  task automatic run_access(input aed_access_t a);
    logic e;
    e = exp_err(a);
    @(posedge sys_clk_in);
    acc_r <= a;
    pc_r <= $urandom & 32'hFFFFFFFE;
    stat_r <= $urandom;
    sp_r <= $urandom & 32'hFFFFFFFC;
    vbase_r <= $urandom & 32'hFFFFFFFC;
    slow_r <= 1'($urandom_range(0, 1));
    @(posedge sys_clk_in);
    acc_r.valid <= 1'b0;
    #1;
    chk_bit(addr_err, e, "error pulse");
    chk_word({29'h0, src}, e ? {29'h0, a.master == AED_M_CPU, a.master == AED_M_DMA,
      a.master == AED_M_EDMA} : 32'h0, "error source");
    if (e) run_entry(a.master == AED_M_CPU ? AED_VEC_CPU_ERR : AED_VEC_DMA_ERR);
  endtask : run_access

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  initial begin
    // Budget well above 318 tests of at most about 25 cycles each
    #(40 * 30000);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    void'($urandom(87631));
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    run_access(mk(AED_M_CPU, AED_SZ_WORD, 4'h8, 32'h00001001));
    run_access(mk(AED_M_CPU, AED_SZ_WORD, 4'h8, 32'h00001000));
    run_access(mk(AED_M_CPU, AED_SZ_WORD, 4'h8, 32'hFFFF1000));
    run_access(mk(AED_M_DMA, AED_SZ_WORD, 4'h0, 32'h00002001));
    run_access(mk(AED_M_EDMA, AED_SZ_WORD, 4'h0, 32'h00002003));
    run_access(mk(AED_M_EDMA, AED_SZ_LONG, 4'h0, 32'h00002002));
    run_access(mk(AED_M_CPU, AED_SZ_LONG, 4'h0, 32'h00002004));
    run_access(mk(AED_M_DMA, AED_SZ_BLK16, 4'h0, 32'h00002006));
    run_access(mk(AED_M_CPU, AED_SZ_LONG, 4'h4, 32'h40000010));
    run_access(mk(AED_M_CPU, AED_SZ_LONG, 4'h4, 32'hC0000010));
    run_access(mk(AED_M_CPU, AED_SZ_BYTE, 4'h2, 32'hC0000011));
    run_access(mk(AED_M_DMA, AED_SZ_BYTE, 4'h0, 32'hFFFFFCFF));
    run_access(mk(AED_M_CPU, AED_SZ_LONG, 4'h0, 32'hFFFFFC00));
    run_access(mk(AED_M_DMA, AED_SZ_LONG, 4'h0, 32'hFFFFFEFC));
    run_access(mk(AED_M_CPU, AED_SZ_BYTE, 4'h0, 32'hFFFFFFFF));
    run_access(mk(AED_M_EDMA, AED_SZ_BYTE, 4'h0, 32'hFFFF0000));
    run_access(mk(AED_M_CPU, AED_SZ_WORD, 4'h0, 32'hFFFFFBFE));
    run_access(mk(AED_M_DMA, AED_SZ_LONG, 4'h1, 32'h00000003));
    $display("test corner done");
    repeat (300) run_access(rand_acc());
    $display("test random done");
    end_sim();
  end
endmodule : address_error_detect_test

/* File: testbench/aed_mem_model.sv */
/*
  Memory side of exception entry: acks each request at once or after a stall, returns handler words.
  Assumes the requester holds each request until it sees the ack.
*/
`timescale 1ns/1ns
module aed_mem_model
  import aed_pkg::*;
#(
  parameter logic [31:0] HANDLER_XOR = 32'hA5A50000
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Request side
  input wire aed_pkg::aed_mem_req_t mem_in,
  input wire logic slow_in,
  // Answer side
  output logic ack_out,
  output logic [31:0] rdata_out
);
  int wait_r;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ack_out <= 1'b0;
      wait_r <= 0;
      rdata_out <= 32'h00000000;
    end else begin
      ack_out <= 1'b0;
      // Idle data flips every cycle so a stale read never looks valid
      rdata_out <= ~rdata_out;
      if (mem_in.req && !ack_out) begin
        if (wait_r == 0) begin
          ack_out <= 1'b1;
          wait_r <= slow_in ? $urandom_range(1, 3) : 0;
          if (!mem_in.write) rdata_out <= mem_in.addr ^ HANDLER_XOR;
        end else wait_r <= wait_r - 1;
      end
    end
  end
endmodule : aed_mem_model
